// ==== logic/seq_run_regs.svh ====
// sequence count, source and error codes and field widths for the sequence run control block
`ifndef SEQ_RUN_REGS_SVH
`define SEQ_RUN_REGS_SVH
`define SEQ_NUM_W 7
`define SEQ_COUNT 100
`define SEQ_SRC_W 2
`define SEQ_SRC_PROMPT 2'h0
`define SEQ_SRC_FIELDBUS 2'h1
`define SEQ_SRC_SEQUENCE 2'h2
`define SEQ_SRC_INPUT 2'h3
`define SEQ_ERR_W 3
`define SEQ_ERR_NONE 3'h0
`define SEQ_ERR_UNKNOWN 3'h1
`define SEQ_ERR_ALARM 3'h2
`define SEQ_ERR_NESTED 3'h3
`define SEQ_ERR_BUSY 3'h4
`define SEQ_ESC_CHAR 8'h1B
`endif

// ==== logic/seq_run_pkg.sv ====
// types for the sequence run control block
package seq_run_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RUNNING,
      ST_ABORTING
   } run_state_e;
   typedef enum logic [1:0] {
      END_NONE,
      END_DONE,
      END_ABORT
   } end_cause_e;
endpackage

// ==== logic/seq_start_check.sv ====
// start request qualification for the sequence run control block
`timescale 1ns/10ps
`include "seq_run_regs.svh"
module seq_start_check (
   input wire logic i_req,
   input wire logic [`SEQ_SRC_W-1:0] i_src,
   input wire logic i_exists,
   input wire logic i_alarm,
   input wire logic i_running,
   output logic o_ok,
   output logic [`SEQ_ERR_W-1:0] o_err
);
   // refusal priority: nested use, alarm, unknown target, busy
   always_comb begin
      o_ok = 1'b0;
      o_err = `SEQ_ERR_NONE;
      if (i_req) begin
         if (i_src == `SEQ_SRC_SEQUENCE) begin
            o_err = `SEQ_ERR_NESTED;
         end else if (i_alarm) begin
            o_err = `SEQ_ERR_ALARM;
         end else if (i_src != `SEQ_SRC_INPUT && !i_exists) begin
            o_err = `SEQ_ERR_UNKNOWN;
         end else if (i_running) begin
            o_err = `SEQ_ERR_BUSY;
         end else begin
            o_ok = 1'b1;
         end
      end
   end
endmodule

// ==== logic/seq_run_ctrl.sv ====
// sequence start, tracking and abort control
`timescale 1ns/10ps
`include "seq_run_regs.svh"
// Notes on behaviour
// - run command starts the named stored sequence
// - target by name or number, must exist; here by number only, start input target unchecked
// - start input also starts a sequence
// - no start while alarm is active
// - prompt returns; sequence runs in background
// - alarm or abort input aborts run
// - abort command or escape aborts run
// - run refused when issued from inside sequence
// - editor blocked while a sequence runs
module seq_run_ctrl (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_run_req,
   input wire logic [`SEQ_SRC_W-1:0] i_run_src,
   input wire logic [`SEQ_NUM_W-1:0] i_run_target,
   input wire logic [`SEQ_COUNT-1:0] i_stored,
   input wire logic [`SEQ_NUM_W-1:0] i_start_target,
   input wire logic i_start_pin,
   input wire logic i_abort_pin,
   input wire logic i_abort_cmd,
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_char,
   input wire logic i_alarm,
   input wire logic i_seq_done,
   input wire logic i_seq_stopped,
   input wire logic i_edit_req,
   output logic o_running,
   output logic [`SEQ_NUM_W-1:0] o_seq_num,
   output logic o_begin,
   output logic o_abort,
   output logic o_prompt,
   output logic o_ack,
   output logic o_err_valid,
   output logic [`SEQ_ERR_W-1:0] o_err_code,
   output logic o_edit_grant,
   output logic o_edit_denied,
   output logic [1:0] o_end_cause
);
   seq_run_pkg::run_state_e state_q, state_d;
   logic [`SEQ_NUM_W-1:0] num_q, num_d;
   logic start_pin_q, start_pin_d;
   logic begin_q, begin_d;
   logic abort_q, abort_d;
   logic prompt_q, prompt_d;
   logic ack_q, ack_d;
   logic err_v_q, err_v_d;
   logic [`SEQ_ERR_W-1:0] err_q, err_d;
   logic grant_q, grant_d;
   logic denied_q, denied_d;
   logic [1:0] cause_q, cause_d;
   logic cmd_ok, pin_ok;
   logic [`SEQ_ERR_W-1:0] cmd_err, pin_err;
   logic pin_rise, abort_now, busy;
   logic running_q, running_d;

   function automatic logic seq_exists(
      input logic [`SEQ_COUNT-1:0] map,
      input logic [`SEQ_NUM_W-1:0] num
   );
      seq_exists = (num < `SEQ_NUM_W'(`SEQ_COUNT)) ? map[num] : 1'b0;
   endfunction

   assign busy = (state_q != seq_run_pkg::ST_IDLE);
   assign pin_rise = i_start_pin && !start_pin_q;
   assign abort_now = i_alarm || i_abort_pin || i_abort_cmd ||
      (i_rx_valid && i_rx_char == `SEQ_ESC_CHAR);

   seq_start_check u_cmd_check (
      .i_req(i_run_req),
      .i_src(i_run_src),
      .i_exists(seq_exists(i_stored, i_run_target)),
      .i_alarm(i_alarm),
      .i_running(busy),
      .o_ok(cmd_ok),
      .o_err(cmd_err)
   );

   // pin start: no stored-map check, a command wins a tie
   seq_start_check u_pin_check (
      .i_req(pin_rise && !i_run_req),
      .i_src(`SEQ_SRC_INPUT),
      .i_exists(seq_exists(i_stored, i_start_target)),
      .i_alarm(i_alarm),
      .i_running(busy),
      .o_ok(pin_ok),
      .o_err(pin_err)
   );

   // next state and pulse outputs; pulses default low
   always_comb begin
      state_d = state_q;
      num_d = num_q;
      start_pin_d = i_start_pin;
      begin_d = 1'b0;
      abort_d = 1'b0;
      prompt_d = 1'b0;
      ack_d = 1'b0;
      err_v_d = 1'b0;
      err_d = err_q;
      cause_d = cause_q;
      grant_d = 1'b0;
      denied_d = 1'b0;
      case (state_q)
         seq_run_pkg::ST_IDLE: begin
            if (cmd_ok && !abort_now) begin
               state_d = seq_run_pkg::ST_RUNNING;
               num_d = i_run_target;
               begin_d = 1'b1;
               ack_d = 1'b1;
               prompt_d = 1'b1;
               cause_d = seq_run_pkg::END_NONE;
            end else if (pin_ok && !abort_now) begin
               state_d = seq_run_pkg::ST_RUNNING;
               num_d = i_start_target;
               begin_d = 1'b1;
               cause_d = seq_run_pkg::END_NONE;
            end
         end
         seq_run_pkg::ST_RUNNING: begin
            // abort outranks a same-cycle completion
            if (abort_now) begin
               state_d = seq_run_pkg::ST_ABORTING;
               abort_d = 1'b1;
            end else if (i_seq_done) begin
               state_d = seq_run_pkg::ST_IDLE;
               cause_d = seq_run_pkg::END_DONE;
            end
         end
         seq_run_pkg::ST_ABORTING: begin
            // wait for the executor to report the stop or a completion
            if (i_seq_stopped || i_seq_done) begin
               state_d = seq_run_pkg::ST_IDLE;
               cause_d = seq_run_pkg::END_ABORT;
            end
         end
         default: begin
            state_d = seq_run_pkg::ST_IDLE;
         end
      endcase
      // refused command: state kept, error reported
      if (cmd_err != `SEQ_ERR_NONE) begin
         err_v_d = 1'b1;
         err_d = cmd_err;
         prompt_d = 1'b1;
      end else if (i_run_req && !cmd_ok) begin
         err_v_d = 1'b0;
      end else if (cmd_ok && abort_now) begin
         err_v_d = 1'b1;
         err_d = `SEQ_ERR_ALARM;
         prompt_d = 1'b1;
      end else if (pin_ok && abort_now) begin
         err_v_d = 1'b1;
         err_d = `SEQ_ERR_ALARM;
      end else if (pin_err != `SEQ_ERR_NONE) begin
         err_v_d = 1'b1;
         err_d = pin_err;
      end
      // editor locked while busy or in the start cycle
      if (i_edit_req) begin
         if (busy || begin_d) begin
            denied_d = 1'b1;
         end else begin
            grant_d = 1'b1;
         end
      end

      // running flag is registered so the output comes from a flop
      running_d = (state_d != seq_run_pkg::ST_IDLE);
   end

   // registers only; next values come from the block above
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_q <= seq_run_pkg::ST_IDLE;
         num_q <= '0;
         start_pin_q <= 1'b0;
         begin_q <= 1'b0;
         abort_q <= 1'b0;
         prompt_q <= 1'b0;
         ack_q <= 1'b0;
         err_v_q <= 1'b0;
         err_q <= `SEQ_ERR_NONE;
         grant_q <= 1'b0;
         denied_q <= 1'b0;
         cause_q <= seq_run_pkg::END_NONE;
         running_q <= 1'b0;
      end else begin
         state_q <= state_d;
         num_q <= num_d;
         start_pin_q <= start_pin_d;
         begin_q <= begin_d;
         abort_q <= abort_d;
         prompt_q <= prompt_d;
         ack_q <= ack_d;
         err_v_q <= err_v_d;
         err_q <= err_d;
         grant_q <= grant_d;
         denied_q <= denied_d;
         cause_q <= cause_d;
         running_q <= running_d;
      end
   end

   // running flag covers the abort drain so the editor stays locked
   assign o_running = running_q;
   assign o_seq_num = num_q;
   assign o_begin = begin_q;
   assign o_abort = abort_q;
   assign o_prompt = prompt_q;
   assign o_ack = ack_q;
   assign o_err_valid = err_v_q;
   assign o_err_code = err_q;
   assign o_edit_grant = grant_q;
   assign o_edit_denied = denied_q;
   assign o_end_cause = cause_q;
endmodule

// ==== sim/seq_exec_model.sv ====
// executor stand-in answering start and abort orders
`timescale 1ns/10ps
module seq_exec_model (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_begin,
   input wire logic i_abort,
   input wire logic [3:0] i_dly,
   output logic o_done,
   output logic o_stopped
);
   logic [3:0] cnt_q;
   logic act_q, abt_q;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         {cnt_q, act_q, abt_q, o_done, o_stopped} <= '0;
      end else begin
         o_done <= act_q && cnt_q == 4'h0 && !abt_q;
         o_stopped <= act_q && cnt_q == 4'h0 && abt_q;
         if (i_begin || i_abort) begin
            {act_q, abt_q, cnt_q} <= {1'b1, i_abort, i_dly};
         end else if (act_q) begin
            act_q <= cnt_q != 4'h0;
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end
endmodule

// ==== sim/seq_run_ctrl_assertions.sv ====
// port checker for the sequence run control block
`timescale 1ns/10ps
`include "seq_run_regs.svh"
module seq_run_ctrl_chk (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_run_req,
   input wire logic [1:0] i_run_src,
   input wire logic [6:0] i_run_target,
   input wire logic [99:0] i_stored,
   input wire logic i_start_pin,
   input wire logic i_abort_pin,
   input wire logic i_abort_cmd,
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_char,
   input wire logic i_alarm,
   input wire logic i_seq_done,
   input wire logic i_seq_stopped,
   input wire logic i_edit_req,
   input wire logic o_running,
   input wire logic o_begin,
   input wire logic o_abort,
   input wire logic [2:0] o_err_code,
   input wire logic o_edit_denied
);
   logic cause, cmd, hit;
   assign cause = i_abort_pin | i_abort_cmd
      | (i_rx_valid && i_rx_char == `SEQ_ESC_CHAR);
   assign cmd = i_run_req && i_run_src < 2'h2;
   assign hit = (i_run_target < 7'(`SEQ_COUNT)) && i_stored[i_run_target];
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   AST_BEGIN: assert property (cmd && hit && !i_alarm && !cause &&
      !o_running |=> o_begin && o_running) else $error("no start");
   AST_NESTED: assert property (i_run_req && i_run_src == 2'h2
      |=> o_err_code == 3'h3 && !o_begin) else $error("nested");
   AST_ALARM: assert property (cmd && (i_alarm ||
      (cause && hit && !o_running))
      |=> o_err_code == 3'h2 && !o_begin) else $error("alarm");
   AST_UNKNOWN: assert property (cmd && !i_alarm && !cause && !hit
      |=> o_err_code == 3'h1 && !o_begin) else $error("unknown");
   AST_BUSY: assert property (cmd && hit && !i_alarm && !cause &&
      o_running && !i_seq_done && !i_seq_stopped
      |=> o_err_code == 3'h4 && o_running) else $error("busy");
   AST_PIN: assert property (!i_start_pin ##1 i_start_pin && !i_run_req
      && !i_alarm && !cause && !o_running |=> o_begin) else $error("pin");
   AST_ABORT: assert property (o_begin ##1 o_running &&
      (cause || i_alarm) |=> o_abort) else $error("abort");
   AST_EDIT: assert property (i_edit_req && o_running
      |=> o_edit_denied) else $error("edit");
   cover property (o_begin);
   cover property (o_abort);
   cover property (o_edit_denied);
endmodule
bind seq_run_ctrl seq_run_ctrl_chk i_chk (.i_clk, .i_arst_n, .i_run_req,
   .i_run_src, .i_run_target, .i_stored, .i_start_pin, .i_abort_pin,
   .i_abort_cmd, .i_rx_valid, .i_rx_char, .i_alarm, .i_seq_done,
   .i_seq_stopped, .i_edit_req,
   .o_running, .o_begin, .o_abort, .o_err_code, .o_edit_denied);

// ==== sim/seq_run_ctrl_tb_top.sv ====
// self-checking bench for the sequence run control block
`timescale 1ns/10ps
module seq_run_ctrl_tb_top;
   logic i_clk, i_arst_n, req, pin, ap, ac, rv, al, ed, dn, st, run, bg, ab;
   logic pr, ev, eg, dd, a, ack;
   logic [1:0] src, cs;
   logic [6:0] tg, sn;
   logic [99:0] sto;
   logic [7:0] rc;
   logic [3:0] dly;
   logic [2:0] ec, e;
   int fail_count, samples_checked, cyc, m, k, n;
   seq_run_ctrl i_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_run_req(req),
      .i_run_src(src), .i_run_target(tg), .i_stored(sto),
      .i_start_target(tg), .i_start_pin(pin), .i_abort_pin(ap),
      .i_abort_cmd(ac), .i_rx_valid(rv), .i_rx_char(rc), .i_alarm(al),
      .i_seq_done(dn), .i_seq_stopped(st), .i_edit_req(ed), .o_running(run),
      .o_seq_num(sn), .o_begin(bg), .o_abort(ab), .o_prompt(pr), .o_ack(ack),
      .o_err_valid(ev), .o_err_code(ec), .o_edit_grant(eg),
      .o_edit_denied(dd), .o_end_cause(cs));
   seq_exec_model i_exec (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_begin(bg),
      .i_abort(ab), .i_dly(dly), .o_done(dn), .o_stopped(st));
   task automatic chk(input logic [7:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   function automatic logic [2:0] xerr(input int m, input logic a, r);
      if (m == 2) return 3'h3;
      if (a) return 3'h2;
      if (m < 2 && !sto[tg]) return 3'h1;
      return r ? 3'h4 : 3'h0;
   endfunction
   task automatic issue(input int m, input logic a, input logic [6:0] t,
      input logic d);
      @(posedge i_clk);
      req <= m < 3;
      pin <= m == 3;
      {src, al, tg, ed} <= {m[1:0], a, t, d};
      @(posedge i_clk);
      {req, pin, al, ed} <= '0;
      #1;
   endtask
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc++;
      if (cyc > 20000) begin
         fail_count++;
         summarize();
      end
   end
   initial begin
      {i_arst_n, req, pin, ap, ac, rv, al, ed, src, tg, dly} = '0;
      rc = 8'h1B;
      void'($urandom(93));
      sto = 100'({$urandom, $urandom, $urandom, $urandom} & ~(128'h1 << 99));
      repeat (6) @(posedge i_clk);
      i_arst_n <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         m = (i < 4) ? i : $urandom % 4;
         a = i == 4 || $urandom % 8 == 0;
         k = $urandom % 5;
         dly <= 4'(4 + $urandom % 12);
         issue(m, a, (i == 0) ? 7'h63 : 7'($urandom % 100), 1'b0);
         e = xerr(m, a, 1'b0);
         chk(bg, e == 0);
         chk(run, e == 0);
         chk(ev, e != 0);
         if (e != 0) chk(ec, e);
         chk(pr, m != 3);
         chk(ack, e == 0 && m < 3);
         if (e == 0) chk(sn, tg);
         if (e == 0 && k != 0) begin
            @(posedge i_clk);
            {al, ap, ac, rv} <= 4'(8 >> (k - 1));
            @(posedge i_clk);
            {al, ap, ac, rv} <= '0;
            #1;
            chk(ab, 1'b1);
         end else if (e == 0 && m < 2) begin
            issue(m, 1'b0, tg, 1'b1);
            chk(ec, xerr(m, 1'b0, 1'b1));
            chk(dd, 1'b1);
         end
         n = 0;
         while (run !== 1'b0 && n < 40) begin
            @(posedge i_clk);
            #1;
            n++;
         end
         chk(run, 1'b0);
         if (e == 0) chk(cs, (k != 0) ? 2'h2 : 2'h1);
         issue(4, 1'b0, tg, 1'b1);
         chk(eg, 1'b1);
      end
      summarize();
   end
endmodule
